// File: battery_status_pkg.sv
package battery_status_pkg;

	// ************************************************************
	// command codes of the words served here
	// ************************************************************
	localparam logic [7:0] CMD_STATUS_WORD = 8'h16;
	localparam logic [7:0] CMD_CYCLE_COUNT = 8'h17;
	localparam logic [7:0] CMD_NOMINAL_CAPACITY = 8'h18;
	localparam logic [7:0] CMD_NOMINAL_VOLTAGE = 8'h19;

	// ************************************************************
	// status word bit masks
	// ************************************************************
	localparam logic [15:0] MASK_OVERCHARGE = 16'h8000;
	localparam logic [15:0] MASK_STOP_CHARGING = 16'h4000;
	localparam logic [15:0] MASK_HIGH_TEMP = 16'h1000;
	localparam logic [15:0] MASK_STOP_DISCHARGING = 16'h0800;
	localparam logic [15:0] MASK_LOW_CAPACITY = 16'h0200;
	localparam logic [15:0] MASK_LOW_RUNTIME = 16'h0100;
	localparam logic [15:0] MASK_CONFIG_LOADED = 16'h0080;
	localparam logic [15:0] MASK_NOT_CHARGING = 16'h0040;
	localparam logic [15:0] MASK_CHARGE_COMPLETE = 16'h0020;
	localparam logic [15:0] MASK_DEPLETED = 16'h0010;
	localparam logic [15:0] MASK_RESERVED = 16'h2408;
	localparam logic [15:0] MASK_ERROR_CODE = 16'h0007;
	localparam logic [15:0] STATUS_RESET = 16'h0000;

	// ************************************************************
	// error codes of the last command
	// ************************************************************
	typedef enum logic [2:0] {
		ERR_OK = 3'h0,
		ERR_BUSY = 3'h1,
		ERR_RESERVED_CODE = 3'h2,
		ERR_UNIMPLEMENTED = 3'h3,
		ERR_WRITE_PROTECT = 3'h4,
		ERR_OVERFLOW = 3'h5,
		ERR_WRONG_LENGTH = 3'h6,
		ERR_UNKNOWN = 3'h7
	} err_code_t;

	// ************************************************************
	// timing and limits
	// ************************************************************
	localparam int CLK_HZ = 40_000_000;
	localparam int FILTER_SECONDS_PER_STEP = 10;
	localparam logic [11:0] FILTER_SCALE = 12'h00a;
	localparam logic [15:0] CYCLE_COUNT_MAX = 16'hffff;
	localparam logic [15:0] CYCLE_COUNT_RESET = 16'h0000;
	localparam logic [7:0] DEPLETED_CLEAR_PCT = 8'h14;
	localparam logic [24:0] PCT_SCALE = 25'h0000064;

	typedef struct packed {
		logic overcharge_alarm;
		logic stop_charging_alarm;
		logic rsvd_13;
		logic high_temp_alarm;
		logic stop_discharging_alarm;
		logic rsvd_10;
		logic low_capacity_alarm;
		logic low_runtime_alarm;
		logic config_loaded_flag;
		logic not_charging_flag;
		logic charge_complete_flag;
		logic depleted_flag;
		logic rsvd_3;
		err_code_t error_code;
	} status_word_t;

	typedef struct packed {
		logic charging_active;
		logic discharge_activity;
		logic activity_pulse;
		logic overcharge_exceeded;
		logic charge_param_out_of_range;
		logic primary_termination;
		logic cell_undervoltage_flag;
		logic [15:0] temperature;
		logic [15:0] max_temperature_limit;
		logic [15:0] pack_voltage;
		logic [15:0] final_empty_threshold;
		logic [15:0] low_empty_threshold;
		logic [15:0] remaining_charge;
		logic [15:0] capacity_alarm_threshold;
		logic [15:0] present_runtime_estimate;
		logic [15:0] averaged_runtime_estimate;
		logic [15:0] runtime_alarm_threshold;
		logic [15:0] full_capacity;
		logic [7:0] battery_low_percent;
		logic [7:0] relative_charge_percent;
		logic [7:0] charge_complete_clear_percent;
	} gauge_meas_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] code;
		logic busy;
		logic reserved_code;
		logic unimplemented;
		logic length_bad;
		logic overflow;
		logic unknown;
	} cmd_req_t;

endpackage : battery_status_pkg

// File: battery_status_flags.sv
module battery_status_flags
	import battery_status_pkg::*;
#(
	parameter int TICKS_PER_SECOND = CLK_HZ
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// gauge measurements and conditions
	input wire gauge_meas_t meas,
	input wire logic [7:0] digital_filter,
	input wire logic energy_units_select,
	// configuration load
	input wire logic config_load_valid,
	input wire logic config_load_bad,
	input wire logic [15:0] stored_cycle_count,
	input wire logic [15:0] capacity_mah,
	input wire logic [15:0] capacity_10mwh,
	input wire logic [15:0] configured_voltage_mv,
	// cycle counting
	input wire logic cycle_increment,
	// command port from the bus engine
	input wire cmd_req_t cmd,
	input wire logic alarm_request,
	// answers
	output status_word_t status_word,
	output logic [15:0] rd_data,
	output logic rd_valid,
	output logic [15:0] alarm_broadcast,
	output logic alarm_valid,
	// cycle count write-back
	output logic [15:0] charge_cycle_count,
	output logic nvm_write
);

	// ************************************************************
	// state
	// ************************************************************
	localparam logic [25:0] TICK_LAST = 26'(TICKS_PER_SECOND - 1);

	typedef struct packed {
		status_word_t st;
		logic [15:0] cycles;
		logic [15:0] rd_data;
		logic rd_valid;
		logic [15:0] alarm_word;
		logic alarm_valid;
		logic nvm_write;
		logic [25:0] prescale;
		logic [11:0] idle_sec;
		logic [15:0] prev_remaining;
		logic [15:0] prev_avg_runtime;
	} state_t;

	state_t s;
	state_t next_s;

	logic [11:0] filter_timeout;
	logic sec_tick;
	logic idle_expired;
	logic own_code;
	logic [24:0] charge_scaled;
	logic [24:0] low_limit;
	err_code_t next_err;
	logic [15:0] read_word;

	// ************************************************************
	// helpers
	// ************************************************************
	always_comb begin
		filter_timeout = FILTER_SCALE * {4'h0, digital_filter};
		sec_tick = (s.prescale == TICK_LAST);
		idle_expired = (s.idle_sec >= filter_timeout) && !meas.activity_pulse;
		own_code = (cmd.code >= CMD_STATUS_WORD) && (cmd.code <= CMD_NOMINAL_VOLTAGE);
		charge_scaled = 25'(meas.remaining_charge) * PCT_SCALE;
		low_limit = 25'(meas.full_capacity) * 25'(meas.battery_low_percent);
	end

	// priority: busy, reserved, unimplemented, write protect, length, overflow, unknown
	always_comb begin
		if (cmd.busy) begin
			next_err = ERR_BUSY;
		end else if (cmd.reserved_code) begin
			next_err = ERR_RESERVED_CODE;
		end else if (cmd.unimplemented) begin
			next_err = ERR_UNIMPLEMENTED;
		end else if (cmd.write && own_code) begin
			next_err = ERR_WRITE_PROTECT;
		end else if (cmd.length_bad) begin
			next_err = ERR_WRONG_LENGTH;
		end else if (cmd.overflow) begin
			next_err = ERR_OVERFLOW;
		end else if (cmd.unknown) begin
			next_err = ERR_UNKNOWN;
		end else begin
			next_err = ERR_OK;
		end
	end

	always_comb begin
		case (cmd.code)
			CMD_STATUS_WORD: begin
				read_word = s.st;
			end
			CMD_CYCLE_COUNT: begin
				read_word = s.cycles;
			end
			CMD_NOMINAL_CAPACITY: begin
				read_word = energy_units_select ? capacity_10mwh : capacity_mah;
			end
			CMD_NOMINAL_VOLTAGE: begin
				read_word = configured_voltage_mv;
			end
			default: begin
				read_word = 16'h0000;
			end
		endcase
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		next_s = s;
		next_s.rd_valid = 1'b0;
		next_s.alarm_valid = 1'b0;
		next_s.nvm_write = 1'b0;
		next_s.prev_remaining = meas.remaining_charge;
		next_s.prev_avg_runtime = meas.averaged_runtime_estimate;

		// one-second prescaler and idle-time counter
		next_s.prescale = sec_tick ? 26'h0000000 : s.prescale + 26'h0000001;
		if (meas.activity_pulse) begin
			next_s.idle_sec = 12'h000;
		end else if (sec_tick && (s.idle_sec != 12'hfff)) begin
			next_s.idle_sec = s.idle_sec + 12'h001;
		end

		// overcharge: set beats the clear
		if (meas.overcharge_exceeded) begin
			next_s.st.overcharge_alarm = 1'b1;
		end else if (meas.discharge_activity || idle_expired) begin
			next_s.st.overcharge_alarm = 1'b0;
		end

		// clearing condition is the inverse of the setting one
		next_s.st.stop_charging_alarm = (meas.charge_param_out_of_range
			|| meas.primary_termination) && meas.charging_active;
		next_s.st.high_temp_alarm =
			(meas.temperature >= meas.max_temperature_limit);
		next_s.st.stop_discharging_alarm =
			(meas.pack_voltage <= meas.final_empty_threshold)
			|| meas.cell_undervoltage_flag
			|| (meas.remaining_charge == 16'h0000);

		// hysteresis at equality: hold until a clear condition shows
		if (meas.remaining_charge < meas.capacity_alarm_threshold) begin
			next_s.st.low_capacity_alarm = 1'b1;
		end else if ((meas.capacity_alarm_threshold < meas.remaining_charge)
			|| (meas.charging_active && (meas.remaining_charge > s.prev_remaining))) begin
			next_s.st.low_capacity_alarm = 1'b0;
		end

		if (meas.present_runtime_estimate < meas.runtime_alarm_threshold) begin
			next_s.st.low_runtime_alarm = 1'b1;
		end else if ((meas.runtime_alarm_threshold < meas.averaged_runtime_estimate)
			|| (meas.charging_active
			&& (meas.averaged_runtime_estimate > s.prev_avg_runtime))) begin
			next_s.st.low_runtime_alarm = 1'b0;
		end

		if (config_load_valid) begin
			next_s.st.config_loaded_flag = 1'b1;
		end else if (config_load_bad) begin
			next_s.st.config_loaded_flag = 1'b0;
		end

		next_s.st.not_charging_flag = !meas.charging_active;

		if (meas.primary_termination || meas.overcharge_exceeded) begin
			next_s.st.charge_complete_flag = 1'b1;
		end else if (meas.relative_charge_percent <= meas.charge_complete_clear_percent) begin
			next_s.st.charge_complete_flag = 1'b0;
		end

		if ((meas.pack_voltage <= meas.low_empty_threshold) || (charge_scaled < low_limit)) begin
			next_s.st.depleted_flag = 1'b1;
		end else if (meas.relative_charge_percent >= DEPLETED_CLEAR_PCT) begin
			next_s.st.depleted_flag = 1'b0;
		end

		// reserved positions never hold anything
		next_s.st.rsvd_13 = 1'b0;
		next_s.st.rsvd_10 = 1'b0;
		next_s.st.rsvd_3 = 1'b0;

		// cycle counter: load from storage, count, saturate, write back
		if (config_load_valid) begin
			next_s.cycles = stored_cycle_count;
		end else if (cycle_increment && (s.cycles != CYCLE_COUNT_MAX)) begin
			next_s.cycles = s.cycles + 16'h0001;
			next_s.nvm_write = 1'b1;
		end

		// command completion: answer with the previous code, then update it
		if (cmd.valid) begin
			next_s.st.error_code = next_err;
			if (!cmd.write && own_code && !cmd.busy) begin
				next_s.rd_data = read_word;
				next_s.rd_valid = 1'b1;
			end
		end

		if (alarm_request) begin
			next_s.alarm_word = {s.st[15:3], ERR_UNKNOWN};
			next_s.alarm_valid = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s <= '0;
			s.st <= STATUS_RESET;
			s.cycles <= CYCLE_COUNT_RESET;
		end else begin
			s <= next_s;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	always_comb begin
		status_word = s.st;
		rd_data = s.rd_data;
		rd_valid = s.rd_valid;
		alarm_broadcast = s.alarm_word;
		alarm_valid = s.alarm_valid;
		charge_cycle_count = s.cycles;
		nvm_write = s.nvm_write;
	end

	// ************************************************************
	// assertions
	// ************************************************************
	a_status_read: assert property (@(posedge clk) disable iff (srst)
		(cmd.valid && !cmd.write && !cmd.busy && (cmd.code == CMD_STATUS_WORD))
		|=> (rd_valid && (rd_data == $past(s.st))))
		else $error("status read did not return the status word");

	a_broadcast_err: assert property (@(posedge clk) disable iff (srst)
		alarm_request |=> (alarm_valid && (alarm_broadcast[2:0] == 3'h7)
		&& (alarm_broadcast[15:3] == $past(s.st[15:3]))))
		else $error("alarm broadcast word wrong");

	a_reserved_zero: assert property (@(posedge clk) disable iff (srst)
		##1 ((status_word & MASK_RESERVED) == 16'h0000))
		else $error("reserved status bit set");

	a_busy_code: assert property (@(posedge clk) disable iff (srst)
		(cmd.valid && cmd.busy) |=> (status_word[2:0] == 3'h1) && !rd_valid)
		else $error("busy command not reported as code 1");

	a_reserved_code: assert property (@(posedge clk) disable iff (srst)
		(cmd.valid && !cmd.busy && cmd.reserved_code) |=> (status_word[2:0] == 3'h2))
		else $error("reserved command not reported as code 2");

	a_unimpl_code: assert property (@(posedge clk) disable iff (srst)
		(cmd.valid && !cmd.busy && !cmd.reserved_code && cmd.unimplemented)
		|=> (status_word[2:0] == 3'h3))
		else $error("unsupported command not reported as code 3");

	a_write_denied: assert property (@(posedge clk) disable iff (srst)
		(cmd.valid && cmd.write && !cmd.busy && !cmd.reserved_code && !cmd.unimplemented
		&& (cmd.code >= CMD_STATUS_WORD) && (cmd.code <= CMD_NOMINAL_VOLTAGE))
		|=> (status_word[2:0] == 3'h4) && !rd_valid)
		else $error("write to read-only word not reported as code 4");

	a_error_hold: assert property (@(posedge clk) disable iff (srst)
		(!cmd.valid ##1 !cmd.valid) |-> $stable(status_word.error_code))
		else $error("error code changed without a command");

	a_cycle_sat: assert property (@(posedge clk) disable iff (srst)
		(cycle_increment && !config_load_valid && (charge_cycle_count == CYCLE_COUNT_MAX))
		|=> ((charge_cycle_count == CYCLE_COUNT_MAX) && !nvm_write))
		else $error("cycle counter wrapped past saturation");

	a_cycle_wb: assert property (@(posedge clk) disable iff (srst)
		(cycle_increment && !config_load_valid && (charge_cycle_count != CYCLE_COUNT_MAX))
		|=> (nvm_write && (charge_cycle_count == $past(charge_cycle_count) + 16'h0001)))
		else $error("cycle count update not written back");

	a_hot_alarm: assert property (@(posedge clk) disable iff (srst)
		##1 (status_word.high_temp_alarm
		== $past(meas.temperature >= meas.max_temperature_limit)))
		else $error("high temperature alarm wrong");

	a_config_set: assert property (@(posedge clk) disable iff (srst)
		config_load_valid |=> status_word.config_loaded_flag)
		else $error("valid configuration load did not set the flag");

	a_depleted_clr: assert property (@(posedge clk) disable iff (srst)
		(status_word.depleted_flag && (meas.relative_charge_percent >= DEPLETED_CLEAR_PCT)
		&& (meas.pack_voltage > meas.low_empty_threshold) && (charge_scaled >= low_limit))
		|=> !status_word.depleted_flag)
		else $error("depleted flag not cleared at 20 percent");

	a_overcharge_clr: assert property (@(posedge clk) disable iff (srst)
		(!meas.overcharge_exceeded && meas.discharge_activity) |=> !status_word[15])
		else $error("overcharge alarm not cleared by discharge");

	a_capacity_sel: assert property (@(posedge clk) disable iff (srst)
		(cmd.valid && !cmd.write && !cmd.busy && (cmd.code == CMD_NOMINAL_CAPACITY))
		|=> (rd_data == $past(energy_units_select ? capacity_10mwh : capacity_mah)))
		else $error("nominal capacity units wrong");

endmodule : battery_status_flags

// File: smbus_host_model.sv
module smbus_host_model
	import battery_status_pkg::*;
(
	// clock
	input wire logic clk,
	// command to the gauge
	output cmd_req_t cmd
);
	timeunit 1ns;
	timeprecision 1ps;

	initial cmd = '0;

	// one-cycle command pulse; all qualifiers ride with valid
	task automatic issue(input logic [7:0] code, input logic wr, input logic [5:0] err);
		@(posedge clk);
		cmd <= {1'b1, wr, code, err};
		@(posedge clk);
		cmd <= '0;
	endtask : issue
endmodule : smbus_host_model

// File: test_battery_status_flags.sv
module test_battery_status_flags
	import battery_status_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 1'b0;
	logic srst = 1'b1;
	gauge_meas_t meas;
	logic [7:0] digital_filter;
	logic energy_units_select;
	logic config_load_valid;
	logic config_load_bad;
	logic [15:0] stored_cycle_count;
	logic [15:0] capacity_mah;
	logic [15:0] capacity_10mwh;
	logic [15:0] configured_voltage_mv;
	logic cycle_increment;
	cmd_req_t cmd;
	logic alarm_request;
	status_word_t status_word;
	logic [15:0] rd_data;
	logic rd_valid;
	logic [15:0] alarm_broadcast;
	logic alarm_valid;
	logic [15:0] charge_cycle_count;
	logic nvm_write;
	int n_mismatch = 0;
	int samples_checked = 0;
	logic [15:0] q [$];
	logic [15:0] fl;
	logic [2:0] ecode [6] = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h5, 3'h7};

	always #12.5 clk = ~clk;

	// idle timeout shortened: 4 ticks a second
	battery_status_flags #(.TICKS_PER_SECOND(4)) battery_status_flags_inst (
		.clk(clk), .srst(srst), .meas(meas), .digital_filter(digital_filter),
		.energy_units_select(energy_units_select), .config_load_valid(config_load_valid),
		.config_load_bad(config_load_bad), .stored_cycle_count(stored_cycle_count),
		.capacity_mah(capacity_mah), .capacity_10mwh(capacity_10mwh),
		.configured_voltage_mv(configured_voltage_mv), .cycle_increment(cycle_increment),
		.cmd(cmd), .alarm_request(alarm_request), .status_word(status_word),
		.rd_data(rd_data), .rd_valid(rd_valid), .alarm_broadcast(alarm_broadcast),
		.alarm_valid(alarm_valid), .charge_cycle_count(charge_cycle_count),
		.nvm_write(nvm_write)
	);

	smbus_host_model smbus_host_model_inst (.clk(clk), .cmd(cmd));

	// ************************************************************
	// comparison and verdict
	// ************************************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic final_report;
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : final_report

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	// ************************************************************
	// answer monitor
	// ************************************************************
	always @(posedge clk) begin
		if (rd_valid === 1'b1 || alarm_valid === 1'b1) begin
			if (q.size() == 0) begin
				n_mismatch++;
				$display("mismatch at %0t: answer with nothing expected", $time);
			end else if (rd_valid === 1'b1) begin
				chk(rd_data, q.pop_front());
			end else begin
				chk(alarm_broadcast, q.pop_front());
			end
		end
	end

	// ************************************************************
	// stimulus
	// ************************************************************
	initial begin
		meas = '0;
		meas.pack_voltage = 16'h0bb8;
		meas.final_empty_threshold = 16'h07d0;
		meas.low_empty_threshold = 16'h09c4;
		meas.remaining_charge = 16'h01f4;
		meas.capacity_alarm_threshold = 16'h0064;
		meas.present_runtime_estimate = 16'h012c;
		meas.averaged_runtime_estimate = 16'h012c;
		meas.runtime_alarm_threshold = 16'h0064;
		meas.full_capacity = 16'h03e8;
		meas.battery_low_percent = 8'h0a;
		meas.relative_charge_percent = 8'h32;
		meas.charge_complete_clear_percent = 8'h1e;
		meas.max_temperature_limit = 16'h0096;
		digital_filter = 8'h01;
		energy_units_select = 1'b0;
		config_load_valid = 1'b0;
		config_load_bad = 1'b0;
		stored_cycle_count = 16'hfffe;
		capacity_mah = 16'h0000;
		capacity_10mwh = 16'h0000;
		configured_voltage_mv = 16'h0000;
		cycle_increment = 1'b0;
		alarm_request = 1'b0;
		void'($urandom(32'hbff975d7));
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		// reset value shows only until the first free edge recomputes the flags
		#1;
		chk(status_word, STATUS_RESET);
		chk(charge_cycle_count, CYCLE_COUNT_RESET);
		@(posedge clk);
		meas.temperature <= 16'($urandom_range(300, 0));
		capacity_mah <= 16'($urandom);
		capacity_10mwh <= 16'($urandom);
		configured_voltage_mv <= 16'($urandom);
		config_load_valid <= 1'b1;
		@(posedge clk);
		config_load_valid <= 1'b0;
		step(1);
		fl = MASK_CONFIG_LOADED | MASK_NOT_CHARGING;
		if (meas.temperature >= meas.max_temperature_limit) fl = fl | MASK_HIGH_TEMP;
		chk(status_word, fl);
		chk(charge_cycle_count, 16'hfffe);
		// count one short of saturation, then one at saturation
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			cycle_increment <= 1'b1;
			@(posedge clk);
			cycle_increment <= 1'b0;
			#1;
			chk(16'(nvm_write), 16'(i == 0));
			chk(charge_cycle_count, CYCLE_COUNT_MAX);
		end
		// every readable word, capacity in both unit modes
		for (int i = 0; i < 5; i++) begin
			energy_units_select <= (i == 4);
			case (i)
				0: q.push_back(fl);
				1: q.push_back(CYCLE_COUNT_MAX);
				2: q.push_back(capacity_mah);
				3: q.push_back(configured_voltage_mv);
				default: q.push_back(capacity_10mwh);
			endcase
			smbus_host_model_inst.issue(CMD_STATUS_WORD + 8'(i < 4 ? i : 2), 1'b0, 6'h00);
		end
		for (int i = 0; i < 6; i++) begin
			smbus_host_model_inst.issue(8'h30, 1'b0, 6'h20 >> i);
			#1;
			chk(16'(status_word.error_code), 16'(ecode[i]));
		end
		smbus_host_model_inst.issue(CMD_NOMINAL_CAPACITY, 1'b1, 6'h04);
		#1;
		chk(16'(status_word.error_code), 16'(ERR_WRITE_PROTECT));
		smbus_host_model_inst.issue(8'h40, 1'b1, 6'h04);
		#1;
		chk(16'(status_word.error_code), 16'(ERR_WRONG_LENGTH));
		smbus_host_model_inst.issue(8'h30, 1'b0, 6'h30);
		// status read shows the busy code left by the previous command
		q.push_back(fl | 16'h0001);
		smbus_host_model_inst.issue(CMD_STATUS_WORD, 1'b0, 6'h00);
		#1;
		chk(16'(status_word.error_code), 16'(ERR_OK));
		q.push_back(fl | MASK_ERROR_CODE);
		@(posedge clk);
		alarm_request <= 1'b1;
		@(posedge clk);
		alarm_request <= 1'b0;
		meas.charging_active <= 1'b1;
		meas.overcharge_exceeded <= 1'b1;
		meas.primary_termination <= 1'b1;
		step(2);
		fl = MASK_OVERCHARGE | MASK_STOP_CHARGING | MASK_NOT_CHARGING | MASK_CHARGE_COMPLETE;
		chk(status_word & fl, fl ^ MASK_NOT_CHARGING);
		meas.overcharge_exceeded <= 1'b0;
		meas.primary_termination <= 1'b0;
		meas.activity_pulse <= 1'b1;
		@(posedge clk);
		meas.activity_pulse <= 1'b0;
		step(30);
		chk(status_word & fl, MASK_OVERCHARGE | MASK_CHARGE_COMPLETE);
		step(20);
		chk(status_word & fl, MASK_CHARGE_COMPLETE);
		// activity restarts the idle count, so only discharge can clear here
		meas.overcharge_exceeded <= 1'b1;
		meas.activity_pulse <= 1'b1;
		@(posedge clk);
		#1;
		chk(16'(status_word.overcharge_alarm), 16'h0001);
		meas.overcharge_exceeded <= 1'b0;
		meas.activity_pulse <= 1'b0;
		meas.discharge_activity <= 1'b1;
		step(1);
		chk(16'(status_word.overcharge_alarm), 16'h0000);
		meas.discharge_activity <= 1'b0;
		meas.relative_charge_percent <= 8'h1e;
		meas.capacity_alarm_threshold <= 16'h0258;
		meas.runtime_alarm_threshold <= 16'h0190;
		meas.cell_undervoltage_flag <= 1'b1;
		meas.pack_voltage <= 16'h09c4;
		step(2);
		fl = MASK_CHARGE_COMPLETE | MASK_LOW_CAPACITY | MASK_LOW_RUNTIME;
		fl = fl | MASK_STOP_DISCHARGING | MASK_DEPLETED;
		chk(status_word & fl, fl ^ MASK_CHARGE_COMPLETE);
		meas.relative_charge_percent <= 8'h13;
		meas.capacity_alarm_threshold <= 16'h0190;
		meas.runtime_alarm_threshold <= 16'h0064;
		meas.cell_undervoltage_flag <= 1'b0;
		meas.pack_voltage <= 16'h0bb8;
		step(2);
		chk(status_word & fl, MASK_DEPLETED);
		meas.relative_charge_percent <= DEPLETED_CLEAR_PCT;
		config_load_bad <= 1'b1;
		@(posedge clk);
		config_load_bad <= 1'b0;
		step(2);
		chk(status_word & (MASK_DEPLETED | MASK_CONFIG_LOADED), 16'h0000);
		chk(16'(q.size()), 16'h0000);
		final_report();
	end
endmodule : test_battery_status_flags
